// ### pkg/ime_pkg.sv
// constants shared by the interrupt-enable, error-source and unit-enable block
package ime_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int EVT_COUNT = 6;
	localparam int ERR_COUNT = 3;
	localparam int EN_W = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_INT_SET = 12'h304;
	localparam logic [ADDR_W-1:0] OFF_INT_CLR = 12'h308;
	localparam logic [ADDR_W-1:0] OFF_ERR_SRC = 12'h4C4;
	localparam logic [ADDR_W-1:0] OFF_UNIT_EN = 12'h500;

	// interrupt enable bit positions: halt done, rx byte ready, tx byte sent,
	// error, byte boundary, suspended
	localparam int unsigned EVT_POS [0:EVT_COUNT-1] = '{1, 2, 7, 9, 14, 18};
	localparam logic [DATA_W-1:0] INT_BIT_MASK = 32'h0004_4286;

	// error source bit positions
	localparam int ERR_OVERRUN = 0;
	localparam int ERR_ADDR_NACK = 1;
	localparam int ERR_DATA_NACK = 2;

	// unit enable field values
	localparam logic [EN_W-1:0] UNIT_ON = 4'h5;
	localparam logic [EN_W-1:0] UNIT_OFF = 4'h0;

	// reset values
	localparam logic [EVT_COUNT-1:0] INT_EN_RESET = 6'h00;
	localparam logic [ERR_COUNT-1:0] ERR_RESET = 3'h0;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// synchroniser depth
	localparam int SYNC_STAGES = 2;

endpackage : ime_pkg

// ### src/ime_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module ime_sync
	import ime_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic async_in,
	output logic      sync_out
);

	logic [SYNC_STAGES-1:0] stage;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage <= '1;
		end else begin
			stage <= {stage[SYNC_STAGES-2:0], async_in};
		end
	end

	assign sync_out = stage[SYNC_STAGES-1];

endmodule : ime_sync

// ### src/ime_ctrl.sv
// interrupt enable, error source and unit enable registers of the two-wire master
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1 - writing one to disable register clears that enable; zero does nothing; reads show enables
// RQ2 - six enable bits: halt, rx ready, tx sent, error, byte boundary, suspended
// RQ3 - suspended event follows the read acknowledge bit, only if suspend was requested
// RQ4 - overrun flag sets when a byte arrives before the previous one was read
// RQ5 - address nack flag sets on nacked address; writing one clears it
// RQ6 - data nack flag sets on nacked data byte; writing one clears it
// RQ7 - error source reads one for each present error, zero otherwise
// RQ8 - unit enabled only when enable field holds five; reset value zero
// RQ9 - set register enables each event on written one; reads match disable register
// RQ10 - error event pulses whenever any error flag gets set
module ime_ctrl
	import ime_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [DATA_W-1:0]    s_axi_wdata,
	input  wire logic [DATA_W/8-1:0]  s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 scl_in,
	input  wire logic                 read_ack_phase,
	input  wire logic                 suspend_request,
	input  wire logic                 resume_request,
	input  wire logic                 rx_byte_arrived,
	input  wire logic                 rx_byte_consumed,
	input  wire logic                 address_nack,
	input  wire logic                 data_nack,
	output logic [EVT_COUNT-1:0]      interrupt_enable,
	output logic                      unit_enabled,
	output logic                      error_event,
	output logic                      suspended_event,
	output logic                      suspended
);

	//////////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic                  aw_held, w_held, wr_exec, wr_hit, rd_hit;
	logic                  scl_sync, scl_prev, scl_fall;
	logic                  suspend_pending, suspend_fire, rx_unread;
	logic [ADDR_W-1:0]     wr_addr;
	logic [DATA_W-1:0]     wr_data, wr_mask, wr_bits;
	logic [DATA_W-1:0]     int_word, next_rdata;
	logic [DATA_W/8-1:0]   wr_strb;
	logic [EVT_COUNT-1:0]  set_bits, clr_bits;
	logic [ERR_COUNT-1:0]  err_src, err_set, err_clr;
	logic [EN_W-1:0]       en_field;

	//////////////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_exec       = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			wr_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			wr_addr <= s_axi_awaddr;
		end else if (wr_exec) begin
			aw_held <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held  <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held  <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (wr_exec) begin
			w_held <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_exec) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// byte lanes without a strobe leave their bits alone
	genvar gb;
	generate
		for (gb = 0; gb < DATA_W/8; gb++) begin : g_lane
			assign wr_mask[gb*8 +: 8] = {8{wr_strb[gb]}};
		end
	endgenerate
	assign wr_bits = wr_data & wr_mask;
	assign wr_hit  = (wr_addr == OFF_INT_SET) || (wr_addr == OFF_INT_CLR) ||
	                 (wr_addr == OFF_ERR_SRC) || (wr_addr == OFF_UNIT_EN);

	//////////////////////////////////////////////////////////////////////////////////////
	// interrupt enables, one bit per event
	genvar ge;
	generate
		for (ge = 0; ge < EVT_COUNT; ge++) begin : g_evt
			assign set_bits[ge] = wr_exec && (wr_addr == OFF_INT_SET) && wr_bits[EVT_POS[ge]];
			assign clr_bits[ge] = wr_exec && (wr_addr == OFF_INT_CLR) && wr_bits[EVT_POS[ge]];
			// RQ2 RQ9 per event enable
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					interrupt_enable[ge] <= INT_EN_RESET[ge];
				end else if (set_bits[ge]) begin
					interrupt_enable[ge] <= 1'b1;
				end else if (clr_bits[ge]) begin
					// RQ1 write one disables
					interrupt_enable[ge] <= 1'b0;
				end
			end
		end
	endgenerate

	// RQ1 RQ9 same readback word
	always_comb begin
		int_word = '0;
		for (int i = 0; i < EVT_COUNT; i++) begin
			int_word[EVT_POS[i]] = interrupt_enable[i];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// unit enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_field <= UNIT_OFF;
		end else if (wr_exec && (wr_addr == OFF_UNIT_EN) && wr_strb[0]) begin
			en_field <= wr_data[EN_W-1:0];
		end
	end

	// RQ8 enabled only at five
	assign unit_enabled = (en_field == UNIT_ON);

	//////////////////////////////////////////////////////////////////////////////////////
	// error sources: a new error wins over a clearing write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_unread <= 1'b0;
		end else if (!unit_enabled) begin
			rx_unread <= 1'b0;
		end else if (rx_byte_arrived) begin
			rx_unread <= 1'b1;
		end else if (rx_byte_consumed) begin
			rx_unread <= 1'b0;
		end
	end
	// RQ4 overrun detect
	assign err_set[ERR_OVERRUN]   = unit_enabled && rx_byte_arrived && rx_unread &&
	                                !rx_byte_consumed;
	// RQ5 address nack
	assign err_set[ERR_ADDR_NACK] = unit_enabled && address_nack;
	// RQ6 data nack
	assign err_set[ERR_DATA_NACK] = unit_enabled && data_nack;
	assign err_clr = (wr_exec && (wr_addr == OFF_ERR_SRC)) ? wr_bits[ERR_COUNT-1:0] : '0;
	// RQ5 RQ6 write one clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_src <= ERR_RESET;
		end else begin
			err_src <= err_set | (err_src & ~err_clr);
		end
	end
	// RQ10 error event pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			error_event <= 1'b0;
		end else begin
			error_event <= |err_set;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// suspend after the acknowledge bit of a read
	ime_sync u_scl_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (scl_in),
		.sync_out (scl_sync)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_prev <= 1'b1;
		end else begin
			scl_prev <= scl_sync;
		end
	end
	assign scl_fall     = scl_prev && !scl_sync;
	// RQ3 only after request
	assign suspend_fire = unit_enabled && scl_fall && read_ack_phase && suspend_pending;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			suspend_pending <= 1'b0;
		end else if (suspend_request && unit_enabled) begin
			suspend_pending <= 1'b1;
		end else if (suspend_fire || resume_request || !unit_enabled) begin
			suspend_pending <= 1'b0;
		end
	end
	// RQ3 event at ack end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			suspended_event <= 1'b0;
			suspended       <= 1'b0;
		end else begin
			suspended_event <= suspend_fire;
			if (suspend_fire) begin
				suspended <= 1'b1;
			end else if (resume_request || !unit_enabled) begin
				suspended <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	// RQ7 error source readback
	always_comb begin
		next_rdata = '0;
		rd_hit     = 1'b1;
		unique case (s_axi_araddr)
			OFF_INT_SET: next_rdata = int_word;
			OFF_INT_CLR: next_rdata = int_word;
			OFF_ERR_SRC: next_rdata[ERR_COUNT-1:0] = err_src;
			OFF_UNIT_EN: next_rdata[EN_W-1:0] = en_field;
			default:     rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_clr_disables;
		(wr_exec && wr_addr == OFF_INT_CLR && (|clr_bits) && !(|set_bits))
			|=> ((interrupt_enable & $past(clr_bits)) == '0);
	endproperty
	a_clr_disables: assert property (p_clr_disables) else $error("disable write left enable"); // RQ1
	property p_zero_no_effect;
		(wr_exec && wr_addr == OFF_INT_CLR && clr_bits == '0) |=> $stable(interrupt_enable);
	endproperty
	a_zero_no_effect: assert property (p_zero_no_effect) else $error("zero write changed"); // RQ1
	property p_set_enables;
		(wr_exec && wr_addr == OFF_INT_SET)
			|=> ((interrupt_enable & $past(set_bits)) == $past(set_bits));
	endproperty
	a_set_enables: assert property (p_set_enables) else $error("set write did not enable"); // RQ9
	property p_int_read;
		(s_axi_arvalid && s_axi_arready &&
		 (s_axi_araddr == OFF_INT_CLR || s_axi_araddr == OFF_INT_SET))
			|=> (s_axi_rdata == $past(int_word)) && ((s_axi_rdata & ~INT_BIT_MASK) == '0);
	endproperty
	a_int_read: assert property (p_int_read) else $error("enable readback wrong"); // RQ2
	property p_suspend_fire;
		(unit_enabled && scl_fall && read_ack_phase && suspend_pending)
			|=> suspended_event ##1 !suspended_event;
	endproperty
	a_suspend_fire: assert property (p_suspend_fire) else $error("suspended event missing"); // RQ3
	property p_suspend_cause;
		suspended_event |-> $past(suspend_pending) && $past(scl_fall);
	endproperty
	a_suspend_cause: assert property (p_suspend_cause) else $error("suspend unasked"); // RQ3
	property p_overrun;
		(unit_enabled && rx_byte_arrived && rx_unread && !rx_byte_consumed)
			|=> err_src[ERR_OVERRUN] && error_event;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RQ4
	property p_address_nack_flag_clear;
		(wr_exec && wr_addr == OFF_ERR_SRC && wr_bits[ERR_ADDR_NACK] && !err_set[ERR_ADDR_NACK])
			|=> !err_src[ERR_ADDR_NACK];
	endproperty
	a_address_nack_flag_clear: assert property (p_address_nack_flag_clear) else $error("address nack not cleared"); // RQ5
	property p_data_nack_flag_set;
		(unit_enabled && data_nack) |=> err_src[ERR_DATA_NACK] [*1] ##0 error_event;
	endproperty
	a_data_nack_flag_set: assert property (p_data_nack_flag_set) else $error("data nack not flagged"); // RQ6
	property p_err_read;
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_ERR_SRC)
			|=> s_axi_rdata == {{(DATA_W-ERR_COUNT){1'b0}}, $past(err_src)};
	endproperty
	a_err_read: assert property (p_err_read) else $error("error source readback wrong"); // RQ7
	property p_unit_on;
		(wr_exec && wr_addr == OFF_UNIT_EN && wr_strb[0])
			|=> unit_enabled == ($past(wr_data[EN_W-1:0]) == UNIT_ON);
	endproperty
	a_unit_on: assert property (p_unit_on) else $error("unit enable decode wrong"); // RQ8
	property p_err_event;
		error_event |-> $past(|err_set);
	endproperty
	a_err_event: assert property (p_err_event) else $error("error event without cause"); // RQ10

	c_write: cover property (wr_exec ##1 s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
	c_suspend: cover property (suspended_event);
	c_overrun: cover property (err_set[ERR_OVERRUN]);

endmodule : ime_ctrl

// ### tb/ime_link_slave.sv
// far-side model: target device framing one byte with its clock line and acknowledge answers
`timescale 1ns/10ps
module ime_link_slave (
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic [1:0] nack_sel,
	output logic            scl_in,
	output logic            read_ack_phase,
	output logic            address_nack,
	output logic            data_nack,
	output logic            busy
);
	int   i;
	logic ack_bit;

	initial begin
		scl_in = 1'b1;
		ack_bit = 1'b0;
		address_nack = 1'b0;
		data_nack = 1'b0;
		busy = 1'b0;
	end

	// acknowledge window handed to the engine side on the block's own clock
	always @(posedge aclk) read_ack_phase <= ack_bit;

	// clock line stands high between frames; 800 ns bits, each edge 37 ns after a rising aclk edge
	always begin
		@(posedge aclk);
		if (go === 1'b1) begin
			busy <= 1'b1;
			#37;
			for (i = 0; i < 9; i++) begin
				scl_in = 1'b0;
				#400;
				scl_in = 1'b1;
				ack_bit = (i == 8);
				#400;
			end
			// last fall closes the acknowledge bit
			scl_in = 1'b0;
			repeat (8) @(posedge aclk);
			ack_bit <= 1'b0;
			address_nack <= nack_sel[0];
			data_nack <= nack_sel[1];
			@(posedge aclk);
			address_nack <= 1'b0;
			data_nack <= 1'b0;
			#37;
			scl_in = 1'b1;
			@(posedge aclk);
			busy <= 1'b0;
		end
	end
endmodule : ime_link_slave

// ### tb/test_ime_ctrl.sv
// testbench for the interrupt enable, error source and unit enable block
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_ime_ctrl
	import ime_pkg::*;
;
	typedef struct {
		logic [11:0] wa; logic [31:0] wd; logic [1:0] eb; logic [11:0] ra;
		logic [31:0] er; logic [1:0] rr; logic [5:0] ie; logic uo;
	} ime_row_type;

	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid, go, busy;
	logic [11:0]       awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb, eng;
	logic [1:0]        bresp, rresp, nsel;
	logic              scl, ackph, address_nack_flag, data_nack_flag, unit_on, err_ev, susp_ev, susp;
	logic [5:0]        int_en;
	int                fails = 0, check_count = 0, ev_cnt = 0, sp_cnt = 0;
	logic [11:0]       offs [4] = '{OFF_INT_SET, OFF_INT_CLR, OFF_ERR_SRC, OFF_UNIT_EN};
	ime_row_type       rows [8] = '{
		'{OFF_INT_SET, 32'hFFFF_FFFF, RESP_OKAY, OFF_INT_CLR, INT_BIT_MASK, RESP_OKAY, 6'h3F, 0},
		'{OFF_INT_CLR, 32'h0000_0002, RESP_OKAY, OFF_INT_SET, 32'h0004_4284, RESP_OKAY, 6'h3E, 0},
		'{OFF_INT_CLR, 32'h0000_0000, RESP_OKAY, OFF_INT_CLR, 32'h0004_4284, RESP_OKAY, 6'h3E, 0},
		'{OFF_INT_CLR, 32'h0004_0080, RESP_OKAY, OFF_INT_SET, 32'h0000_4204, RESP_OKAY, 6'h1A, 0},
		'{OFF_UNIT_EN, 32'h0000_0005, RESP_OKAY, OFF_UNIT_EN, 32'h0000_0005, RESP_OKAY, 6'h1A, 1},
		'{OFF_UNIT_EN, 32'h0000_0004, RESP_OKAY, OFF_UNIT_EN, 32'h0000_0004, RESP_OKAY, 6'h1A, 0},
		'{OFF_UNIT_EN, 32'h0000_0005, RESP_OKAY, OFF_UNIT_EN, 32'h0000_0005, RESP_OKAY, 6'h1A, 1},
		'{12'h400, 32'hFFFF_FFFF, RESP_SLVERR, 12'h400, 32'h0000_0000, RESP_SLVERR, 6'h1A, 1}};

	ime_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl),
		.read_ack_phase(ackph), .suspend_request(eng[0]), .resume_request(eng[1]),
		.rx_byte_arrived(eng[2]), .rx_byte_consumed(eng[3]), .address_nack(address_nack_flag),
		.data_nack(data_nack_flag), .interrupt_enable(int_en), .unit_enabled(unit_on),
		.error_event(err_ev), .suspended_event(susp_ev), .suspended(susp));

	ime_link_slave peer (.aclk(aclk), .go(go), .nack_sel(nsel), .scl_in(scl),
		.read_ack_phase(ackph), .address_nack(address_nack_flag), .data_nack(data_nack_flag), .busy(busy));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (err_ev === 1'b1) ev_cnt <= ev_cnt + 1;
		if (susp_ev === 1'b1) sp_cnt <= sp_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("counts: %0d checks, %0d mismatches", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out

	task automatic hang();
		fails++;
		$display("[ERR] wait exp done got timeout");
		close_out();
	endtask : hang

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic b;
		b = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				b = 1'b1;
				bready <= 1'b0;
			end
		end
		if (!b) hang();
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic b;
		b = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				b = 1'b1;
				rready <= 1'b0;
			end
		end
		if (!b) hang();
	endtask : rd

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK("rdata", e, d)
		`CHK("rresp", RESP_OKAY, r)
	endtask : rchk

	task automatic pulse(input logic [3:0] m);
		@(posedge aclk);
		eng <= m;
		@(posedge aclk);
		eng <= 4'h0;
	endtask : pulse

	task automatic frame(input logic [1:0] s);
		@(posedge aclk);
		nsel <= s;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		for (int n = 0; n < 200 && busy !== 1'b0; n++) @(posedge aclk);
		if (busy !== 1'b0) hang();
		repeat (3) @(posedge aclk);
	endtask : frame

	////////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          e0, s0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, go} = '0;
		{awaddr, araddr, wdata, eng, nsel} = '0;
		wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (offs[i]) rchk(offs[i], 32'h0);
		`CHK("unit_on", 1'b0, unit_on)
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd, r);
			`CHK("bresp", rows[i].eb, r)
			rd(rows[i].ra, d, r);
			`CHK("rdata", rows[i].er, d)
			`CHK("rresp", rows[i].rr, r)
			`CHK("int_en", rows[i].ie, int_en)
			`CHK("unit_on", rows[i].uo, unit_on)
		end
		$display("test rows done");
		pulse(4'h4);
		pulse(4'h8);
		pulse(4'h4);
		e0 = ev_cnt;
		rchk(OFF_ERR_SRC, 32'h0);
		pulse(4'h4);
		repeat (3) @(posedge aclk);
		`CHK("ev_cnt", e0 + 1, ev_cnt)
		rchk(OFF_ERR_SRC, 32'h1);
		wr(OFF_ERR_SRC, 32'h1, r);
		rchk(OFF_ERR_SRC, 32'h0);
		$display("test overrun done");
		frame(2'h1);
		rchk(OFF_ERR_SRC, 32'h2);
		frame(2'h2);
		rchk(OFF_ERR_SRC, 32'h6);
		`CHK("ev_cnt", e0 + 3, ev_cnt)
		wr(OFF_ERR_SRC, 32'h2, r);
		rchk(OFF_ERR_SRC, 32'h4);
		wr(OFF_ERR_SRC, 32'h4, r);
		rchk(OFF_ERR_SRC, 32'h0);
		$display("test nack done");
		s0 = sp_cnt;
		frame(2'h0);
		`CHK("sp_cnt", s0, sp_cnt)
		pulse(4'h1);
		frame(2'h0);
		`CHK("sp_cnt", s0 + 1, sp_cnt)
		`CHK("susp", 1'b1, susp)
		pulse(4'h2);
		@(posedge aclk);
		`CHK("susp", 1'b0, susp)
		$display("test suspend done");
		wr(OFF_UNIT_EN, 32'h0, r);
		e0 = ev_cnt;
		pulse(4'h4);
		pulse(4'h4);
		frame(2'h3);
		rchk(OFF_ERR_SRC, 32'h0);
		`CHK("ev_cnt", e0, ev_cnt)
		$display("test disabled done");
		wr(OFF_UNIT_EN, 32'h5, r);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("int_en", 6'h00, int_en)
		foreach (offs[i]) rchk(offs[i], 32'h0);
		`CHK("unit_on", 1'b0, unit_on)
		$display("test reset again done");
		close_out();
	end
endmodule : test_ime_ctrl
